// ===== logic/uic_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - input type 0..5 enables matching sub-functions
// - mains filter select only for analog, default 50Hz
// - range min/max scale value for consumers
// - error min/max thresholds raise diagnostics
// - digital mode drives pull select 0/1/2
// - logic type decode, default normal
// - normal: state follows ON as 1
// - inverse: state is 0 while ON
// - latched: toggle on each OFF-to-ON
// - inverse latched: toggle on each ON-to-OFF
// - configurable debounce on digital input
// - pulse glitch filter, 111ns/1.78us/14.22us
// - pulses per revolution above 0 gives RPM
// - analog data filter select, default none
// - no filter passes latest raw sample
// - moving average step each 1ms tick
// - repeating average every Nth 1ms sample
// - errors only when enabled, clear with hysteresis
// - one error delay for all diagnostics
module uic_top
	import uic_pkg::*;
#(
	parameter int MS_CYCLES = UIC_MS_CYC,
	parameter int GATE_CYCLES = UIC_GATE_CYC
) (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measurement side
	input wire logic [15:0] meas_data,
	input wire logic meas_valid,
	input wire logic dig_in,
	input wire logic pulse_in,
	// conditioned results
	output logic [1:0] analog_filter_sel,
	output logic [1:0] pull_sel,
	output logic dig_state,
	output logic [15:0] input_value,
	output logic [15:0] scaled_value,
	output logic err_low,
	output logic err_high
);
	logic [31:0] ctrl_q, range_q, errthr_q, errcfg_q;
	logic [15:0] debnc_q, fconst_q, ppr_q;
	logic [31:0] rdata_d;
	logic hit_d;
	logic [31:0] prdata_q, freq_q;
	logic pready_q, pslverr_q;
	uic_type_t in_type;
	uic_logic_t lg_type;
	uic_dfilt_t df_type;
	logic is_analog, is_dig, is_pulse;
	logic [31:0] ms_cnt_q;
	logic tick_q;

	function automatic logic [15:0] nz(input logic [15:0] v);
		nz = (v == 16'h0000) ? 16'h0001 : v;
	endfunction

	assign in_type = uic_type_t'(ctrl_q[UIC_TYPE_LSB +: 3]);
	assign lg_type = uic_logic_t'(ctrl_q[UIC_LOGIC_LSB +: 3]);
	assign df_type = uic_dfilt_t'(ctrl_q[UIC_DFILT_LSB +: 2]);
	// sub-functions follow the selected type
	assign is_analog = (in_type == UIC_IN_VOLT) || (in_type == UIC_IN_CURR);
	assign is_dig = (in_type == UIC_IN_DIG);
	assign is_pulse = (in_type == UIC_IN_FREQ) || (in_type == UIC_IN_PWM);

	// 1 ms time base shared by debounce, filters and error delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (ce) begin
			tick_q <= (ms_cnt_q == 32'(MS_CYCLES - 1));
			if (ms_cnt_q == 32'(MS_CYCLES - 1))
				ms_cnt_q <= 32'h0000_0000;
			else
				ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
		end
	end

	// apb: zero wait states, pready rises in the access cycle
	always_comb begin
		hit_d = 1'b1;
		rdata_d = 32'h0000_0000;
		case (paddr)
			UIC_CTRL_OFS: rdata_d = ctrl_q;
			UIC_RANGE_OFS: rdata_d = range_q;
			UIC_ERRTHR_OFS: rdata_d = errthr_q;
			UIC_ERRCFG_OFS: rdata_d = errcfg_q;
			UIC_DEBNC_OFS: rdata_d = {16'h0000, debnc_q};
			UIC_FCONST_OFS: rdata_d = {16'h0000, fconst_q};
			UIC_PPR_OFS: rdata_d = {16'h0000, ppr_q};
			UIC_VALUE_OFS: rdata_d = {16'h0000, input_value};
			UIC_SCALED_OFS: rdata_d = {16'h0000, scaled_value};
			UIC_STATUS_OFS: rdata_d = {29'h0000_0000, err_high, err_low,
				dig_state};
			UIC_FREQ_OFS: rdata_d = freq_q;
			default: hit_d = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !hit_d;
			if (psel && !penable)
				prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	logic wr_en;
	assign wr_en = psel && penable && pready_q && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= {7'h00, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, UIC_LOGIC_RST,
				2'h0, 2'h0, 2'h0, UIC_AFILT_RST, 4'h0};
			range_q <= {UIC_RANGE_MAX_RST, 16'h0000};
			errthr_q <= {UIC_RANGE_MAX_RST, 16'h0000};
			errcfg_q <= 32'h0000_0000;
			debnc_q <= 16'h0000;
			fconst_q <= UIC_FCONST_RST;
			ppr_q <= 16'h0000;
		end else if (ce && wr_en) begin
			case (paddr)
				UIC_CTRL_OFS: ctrl_q <= pwdata & 32'h0133_7337;
				UIC_RANGE_OFS: range_q <= pwdata;
				UIC_ERRTHR_OFS: errthr_q <= pwdata;
				UIC_ERRCFG_OFS: errcfg_q <= pwdata;
				UIC_DEBNC_OFS: debnc_q <= pwdata[15:0];
				UIC_FCONST_OFS: fconst_q <= pwdata[15:0];
				UIC_PPR_OFS: ppr_q <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// pin selects: zero when the type does not use them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_filter_sel <= 2'h0;
			pull_sel <= 2'h0;
		end else if (ce) begin
			analog_filter_sel <= is_analog ?
				ctrl_q[UIC_AFILT_LSB +: 2] : 2'h0;
			pull_sel <= (is_dig && ctrl_q[UIC_PULL_LSB +: 2] != 2'h3) ?
				ctrl_q[UIC_PULL_LSB +: 2] : 2'h0;
		end
	end

	// digital debounce, counted in ms ticks
	logic cand_q, stable_q, stable_prev_q;
	logic [15:0] deb_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cand_q <= 1'b0;
			stable_q <= 1'b0;
			deb_cnt_q <= 16'h0000;
		end else if (ce) begin
			if (dig_in != cand_q) begin
				cand_q <= dig_in;
				deb_cnt_q <= 16'h0000;
			end else if (deb_cnt_q >= debnc_q) begin
				stable_q <= cand_q;
			end else if (tick_q) begin
				deb_cnt_q <= deb_cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_prev_q <= 1'b0;
			dig_state <= 1'b0;
		end else if (ce) begin
			stable_prev_q <= stable_q;
			if (!is_dig) begin
				dig_state <= 1'b0;
			end else begin
				case (lg_type)
					UIC_LG_NORM: dig_state <= stable_q;
					UIC_LG_INV: dig_state <= !stable_q;
					UIC_LG_LATCH:
						if (stable_q && !stable_prev_q)
							dig_state <= !dig_state;
					UIC_LG_INVLATCH:
						if (!stable_q && stable_prev_q)
							dig_state <= !dig_state;
					default: dig_state <= 1'b0;
				endcase
			end
		end
	end

	// pulse glitch filter: a level must hold for the minimum width
	logic [11:0] glw_d, gl_cnt_q;
	logic pf_q, pf_prev_q;
	always_comb begin
		case (ctrl_q[UIC_GLITCH_LSB +: 2])
			2'h1: glw_d = UIC_G1_CYC;
			2'h2: glw_d = UIC_G2_CYC;
			2'h3: glw_d = UIC_G3_CYC;
			default: glw_d = 12'h000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pf_q <= 1'b0;
			gl_cnt_q <= 12'h000;
		end else if (ce) begin
			if (pulse_in == pf_q) begin
				gl_cnt_q <= 12'h000;
			end else if (gl_cnt_q + 12'h001 >= glw_d) begin
				pf_q <= pulse_in;
				gl_cnt_q <= 12'h000;
			end else begin
				gl_cnt_q <= gl_cnt_q + 12'h001;
			end
		end
	end

	// 1 s gate: edge count gives Hz or RPM, high time gives duty
	logic [31:0] gate_cnt_q, edge_cnt_q, high_cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pf_prev_q <= 1'b0;
			gate_cnt_q <= 32'h0000_0000;
			edge_cnt_q <= 32'h0000_0000;
			high_cnt_q <= 32'h0000_0000;
			freq_q <= 32'h0000_0000;
		end else if (ce) begin
			pf_prev_q <= pf_q;
			if (!is_pulse) begin
				gate_cnt_q <= 32'h0000_0000;
				edge_cnt_q <= 32'h0000_0000;
				high_cnt_q <= 32'h0000_0000;
				freq_q <= 32'h0000_0000;
			end else if (gate_cnt_q == 32'(GATE_CYCLES - 1)) begin
				gate_cnt_q <= 32'h0000_0000;
				edge_cnt_q <= 32'h0000_0000;
				high_cnt_q <= 32'h0000_0000;
				if (in_type == UIC_IN_PWM)
					freq_q <= high_cnt_q * UIC_PERMILLE / 32'(GATE_CYCLES);
				else if (ppr_q != 16'h0000)
					freq_q <= edge_cnt_q * UIC_SEC_PER_MIN /
						{16'h0000, ppr_q};
				else
					freq_q <= edge_cnt_q;
			end else begin
				gate_cnt_q <= gate_cnt_q + 32'h0000_0001;
				if (pf_q && !pf_prev_q)
					edge_cnt_q <= edge_cnt_q + 32'h0000_0001;
				if (pf_q)
					high_cnt_q <= high_cnt_q + 32'h0000_0001;
			end
		end
	end

	// analog data filter
	logic [15:0] raw_q, rep_n_q;
	logic [31:0] acc_q;
	logic signed [17:0] mv_diff;
	assign mv_diff = $signed({2'b00, raw_q}) - $signed({2'b00, input_value});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			raw_q <= 16'h0000;
		else if (ce && meas_valid)
			raw_q <= meas_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_value <= 16'h0000;
			acc_q <= 32'h0000_0000;
			rep_n_q <= 16'h0000;
		end else if (ce) begin
			if (is_pulse) begin
				input_value <= freq_q[15:0];
			end else if (!is_analog) begin
				input_value <= 16'h0000;
			end else begin
				case (df_type)
					UIC_DF_MOVAVG: if (tick_q)
						input_value <= 16'(input_value + 16'(mv_diff /
							$signed({2'b00, nz(fconst_q)})));
					UIC_DF_REPAVG: if (tick_q) begin
						if (rep_n_q + 16'h0001 >= nz(fconst_q)) begin
							input_value <= 16'((acc_q + {16'h0000, raw_q}) /
								{16'h0000, nz(fconst_q)});
							acc_q <= 32'h0000_0000;
							rep_n_q <= 16'h0000;
						end else begin
							acc_q <= acc_q + {16'h0000, raw_q};
							rep_n_q <= rep_n_q + 16'h0001;
						end
					end
					default: input_value <= raw_q;
				endcase
			end
		end
	end

	// range scaling to 0.01 % steps, clamped at the limits
	logic [15:0] rmin, rmax;
	assign rmin = range_q[15:0];
	assign rmax = range_q[UIC_HI_LSB +: 16];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			scaled_value <= 16'h0000;
		else if (ce) begin
			if (rmax <= rmin || input_value <= rmin)
				scaled_value <= 16'h0000;
			else if (input_value >= rmax)
				scaled_value <= UIC_SCALE_FULL;
			else
				scaled_value <= 16'(({16'h0000, input_value - rmin} *
					{16'h0000, UIC_SCALE_FULL}) /
					{16'h0000, rmax - rmin});
		end
	end

	// error conditions with clear hysteresis, then one shared delay
	logic [16:0] emin, emax, hyst, v17;
	logic [1:0] cond_q;
	logic [15:0] edly_q [2];
	logic err_en;
	assign emin = {1'b0, errthr_q[15:0]};
	assign emax = {1'b0, errthr_q[UIC_HI_LSB +: 16]};
	assign hyst = {1'b0, errcfg_q[15:0]};
	assign v17 = {1'b0, input_value};
	assign err_en = ctrl_q[UIC_ERREN_BIT] && (is_analog || is_pulse);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q <= 2'b00;
		end else if (ce) begin
			if (!err_en) begin
				cond_q <= 2'b00;
			end else begin
				if (v17 < emin)
					cond_q[0] <= 1'b1;
				else if (v17 >= emin + hyst)
					cond_q[0] <= 1'b0;
				if (v17 > emax)
					cond_q[1] <= 1'b1;
				else if (v17 + hyst <= emax)
					cond_q[1] <= 1'b0;
			end
		end
	end

	// a diagnostic goes active once its condition held for the delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edly_q[0] <= 16'h0000;
			edly_q[1] <= 16'h0000;
			err_low <= 1'b0;
			err_high <= 1'b0;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if (!cond_q[i])
					edly_q[i] <= 16'h0000;
				else if (tick_q && edly_q[i] < errcfg_q[UIC_HI_LSB +: 16])
					edly_q[i] <= edly_q[i] + 16'h0001;
			end
			err_low <= cond_q[0] &&
				edly_q[0] >= errcfg_q[UIC_HI_LSB +: 16];
			err_high <= cond_q[1] &&
				edly_q[1] >= errcfg_q[UIC_HI_LSB +: 16];
		end
	end
endmodule
`default_nettype wire

// ===== shared/uic_pkg.sv
`default_nettype none
package uic_pkg;
	// register byte offsets
	localparam logic [7:0] UIC_CTRL_OFS = 8'h00;
	localparam logic [7:0] UIC_RANGE_OFS = 8'h04;
	localparam logic [7:0] UIC_ERRTHR_OFS = 8'h08;
	localparam logic [7:0] UIC_ERRCFG_OFS = 8'h0c;
	localparam logic [7:0] UIC_DEBNC_OFS = 8'h10;
	localparam logic [7:0] UIC_FCONST_OFS = 8'h14;
	localparam logic [7:0] UIC_PPR_OFS = 8'h18;
	localparam logic [7:0] UIC_VALUE_OFS = 8'h1c;
	localparam logic [7:0] UIC_SCALED_OFS = 8'h20;
	localparam logic [7:0] UIC_STATUS_OFS = 8'h24;
	localparam logic [7:0] UIC_FREQ_OFS = 8'h28;

	// control register field positions, upper half lsb of the other registers
	localparam int UIC_TYPE_LSB = 0;
	localparam int UIC_AFILT_LSB = 4;
	localparam int UIC_PULL_LSB = 8;
	localparam int UIC_LOGIC_LSB = 12;
	localparam int UIC_GLITCH_LSB = 16;
	localparam int UIC_DFILT_LSB = 20;
	localparam int UIC_ERREN_BIT = 24;
	localparam int UIC_HI_LSB = 16;

	// reset values, scaled full scale
	localparam logic [1:0] UIC_AFILT_RST = 2'h1;
	localparam logic [2:0] UIC_LOGIC_RST = 3'h1;
	localparam logic [15:0] UIC_FCONST_RST = 16'h0001;
	localparam logic [15:0] UIC_RANGE_MAX_RST = 16'hffff;
	localparam logic [15:0] UIC_SCALE_FULL = 16'h2710;

	// timing
	localparam int UIC_CLK_PS = 5000;
	localparam int UIC_MS_PS = 1000000000;
	localparam int UIC_MS_CYC = UIC_MS_PS / UIC_CLK_PS;
	localparam int UIC_GATE_MS = 1000;
	localparam int UIC_GATE_CYC = UIC_MS_CYC * UIC_GATE_MS;
	localparam int UIC_G1_PS = 111000;
	localparam int UIC_G2_PS = 1780000;
	localparam int UIC_G3_PS = 14220000;
	localparam logic [11:0] UIC_G1_CYC =
		12'((UIC_G1_PS + UIC_CLK_PS - 1) / UIC_CLK_PS);
	localparam logic [11:0] UIC_G2_CYC =
		12'((UIC_G2_PS + UIC_CLK_PS - 1) / UIC_CLK_PS);
	localparam logic [11:0] UIC_G3_CYC =
		12'((UIC_G3_PS + UIC_CLK_PS - 1) / UIC_CLK_PS);
	localparam logic [31:0] UIC_SEC_PER_MIN = 32'h0000_003c;
	localparam logic [31:0] UIC_PERMILLE = 32'h0000_03e8;

	typedef enum logic [2:0] {
		UIC_IN_OFF, UIC_IN_VOLT, UIC_IN_CURR,
		UIC_IN_DIG, UIC_IN_FREQ, UIC_IN_PWM
	} uic_type_t;

	typedef enum logic [2:0] {
		UIC_LG_NONE, UIC_LG_NORM, UIC_LG_INV,
		UIC_LG_LATCH, UIC_LG_INVLATCH
	} uic_logic_t;

	typedef enum logic [1:0] {
		UIC_DF_NONE, UIC_DF_MOVAVG, UIC_DF_REPAVG
	} uic_dfilt_t;
endpackage
`default_nettype wire

// ===== test/uic_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module uic_monitor
	import uic_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// results
	input wire logic dig_in,
	input wire logic [1:0] analog_filter_sel,
	input wire logic [1:0] pull_sel,
	input wire logic dig_state,
	input wire logic [15:0] scaled_value,
	input wire logic err_low,
	input wire logic err_high
);
	logic [2:0] quiet_q;
	// a mode write may move the state without any debounce
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_q <= 3'h0;
		end else if (pready && pwrite) begin
			quiet_q <= 3'h0;
		end else if (quiet_q != 3'h7) begin
			quiet_q <= quiet_q + 3'h1;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	chk_apb_answer: assert property (s_setup |=> s_answer)
		else $error("apb answer missing or held");
	chk_apb_decode: assert property (pready && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > UIC_FREQ_OFS))
		else $error("slave error decode wrong");
	chk_err_rdata: assert property (pready && pslverr
		|-> prdata == 32'h0000_0000)
		else $error("error read data not zero");
	chk_one_function: assert property (
		!(analog_filter_sel != 2'h0 && pull_sel != 2'h0))
		else $error("analog and digital both active");
	chk_reset_idle: assert property ($rose(presetn)
		|-> analog_filter_sel == 2'h0 && pull_sel == 2'h0 && !dig_state)
		else $error("outputs not idle after reset");
	chk_debounce_stable: assert property (
		$changed(dig_state) && quiet_q == 3'h7
		|-> $past(dig_in) == $past(dig_in, 2))
		else $error("state moved on unstable input");
	chk_scale_clamp: assert property (
		scaled_value <= UIC_SCALE_FULL)
		else $error("scaled value above full scale");
	chk_err_typed: assert property (
		pull_sel != 2'h0 [*4] |-> !err_low && !err_high)
		else $error("error flag in digital mode");
endmodule
`default_nettype wire

// ===== test/uic_partner.sv
`timescale 1ns/100ps
`default_nettype none
module uic_partner (
	// clock
	input wire logic pclk,
	// sensor side
	output logic [15:0] meas_data,
	output logic meas_valid,
	output logic dig_in,
	output logic pulse_in
);
	int half = 0;
	int cnt = 0;
	initial begin
		meas_data = 16'h0000;
		meas_valid = 1'b0;
		dig_in = 1'b0;
		pulse_in = 1'b0;
	end
	// pulse source; half period in clocks, 0 parks the pin low
	always @(posedge pclk) begin
		if (half == 0) begin
			cnt <= 0;
			pulse_in <= 1'b0;
		end else if (cnt >= half - 1) begin
			cnt <= 0;
			pulse_in <= !pulse_in;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// data is not held once the strobe drops, so a late read shows it
	task automatic sample(input logic [15:0] v);
		@(posedge pclk);
		meas_data <= v;
		meas_valid <= 1'b1;
		@(posedge pclk);
		meas_data <= ~v;
		meas_valid <= 1'b0;
	endtask
	task automatic level(input logic v, input int n);
		@(posedge pclk);
		dig_in <= v;
		repeat (n) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ===== test/universal_input_conditioning_bench.sv
`timescale 1ns/100ps
`default_nettype none
module universal_input_conditioning_bench
	import uic_pkg::*;
;
	logic pclk, presetn, ce;
	logic psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, meas_valid, dig_in, pulse_in, dig_state;
	logic err_low, err_high;
	logic [15:0] meas_data, input_value, scaled_value;
	logic [1:0] analog_filter_sel, pull_sel;
	int n_mismatch = 0;
	int checks = 0;
	// short tick and gate keep the run small
	uic_top #(.MS_CYCLES(20), .GATE_CYCLES(200)) DUT (.pclk, .presetn,
		.ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .meas_data, .meas_valid, .dig_in, .pulse_in,
		.analog_filter_sel, .pull_sel, .dig_state, .input_value,
		.scaled_value, .err_low, .err_high);
	uic_partner P (.pclk, .meas_data, .meas_valid, .dig_in, .pulse_in);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic conclude();
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		chk(32'(pready), 1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		bus(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		bus(1'b0, a, 32'h0000_0000, q, e);
		chk(q, x);
	endtask
	task automatic rd_in(input int lo, input int hi);
		logic [31:0] q;
		logic e;
		bus(1'b0, UIC_FREQ_OFS, 32'h0000_0000, q, e);
		chk(32'(q >= lo && q <= hi), 1);
	endtask
	task automatic next_value(input logic [15:0] x);
		logic [15:0] v;
		int n;
		@(negedge pclk);
		v = input_value;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (input_value === v && n < 100);
		chk(32'(input_value), 32'(x));
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		rd(UIC_CTRL_OFS, 32'h0000_1010);
		rd(UIC_RANGE_OFS, 32'hffff_0000);
		rd(UIC_ERRTHR_OFS, 32'hffff_0000);
		rd(UIC_FCONST_OFS, 32'h0000_0001);
		chk(32'(analog_filter_sel), 0);
		wr(UIC_VALUE_OFS, 32'h0000_ffff);
		rd(UIC_VALUE_OFS, 32'h0000_0000);
		bus(1'b0, 8'h2c, 32'h0000_0000, q, e);
		chk(32'(e), 1);
		chk(q, 0);
	endtask
	task automatic t_select();
		for (int t = 0; t < 6; t++) begin
			for (int c = 0; c < 4; c++) begin
				wr(UIC_CTRL_OFS, 32'(t) | 32'(c) << 4 | 32'(c) << 8 | 32'h1000);
				repeat (6) @(posedge pclk);
				chk(32'(analog_filter_sel), (t == 1 || t == 2) ? c : 0);
				chk(32'(pull_sel), (t == 3 && c < 3) ? c : 0);
			end
		end
	endtask
	task automatic t_logic();
		logic s, eon, eoff;
		wr(UIC_DEBNC_OFS, 32'h0000_0000);
		for (int m = 0; m < 5; m++) begin
			wr(UIC_CTRL_OFS, 32'h0000_0003 | 32'(m) << 12);
			P.level(1'b0, 10);
			s = dig_state;
			eon = (m == 1) | (m == 3 & !s) | (m == 4 & s);
			eoff = (m == 2) | (m == 3 & !s) | (m == 4 & !s);
			P.level(1'b1, 10);
			chk(32'(dig_state), 32'(eon));
			P.level(1'b0, 10);
			chk(32'(dig_state), 32'(eoff));
		end
	endtask
	task automatic t_debounce();
		wr(UIC_CTRL_OFS, 32'h0000_1003);
		wr(UIC_DEBNC_OFS, 32'h0000_0002);
		P.level(1'b0, 80);
		P.level(1'b1, 10);
		chk(32'(dig_state), 0);
		P.level(1'b0, 80);
		P.level(1'b1, 15);
		chk(32'(dig_state), 0);
		repeat (80) @(posedge pclk);
		chk(32'(dig_state), 1);
	endtask
	task automatic t_filter();
		wr(UIC_CTRL_OFS, 32'h0000_1011);
		P.sample(16'h1234);
		repeat (3) @(posedge pclk);
		chk(32'(input_value), 32'h1234);
		rd(UIC_VALUE_OFS, 32'h0000_1234);
		P.sample(16'h0100);
		wr(UIC_FCONST_OFS, 32'h0000_0002);
		wr(UIC_CTRL_OFS, 32'h0010_1011);
		P.sample(16'h0300);
		next_value(16'h0200);
		next_value(16'h0280);
		wr(UIC_FCONST_OFS, 32'h0000_0004);
		wr(UIC_CTRL_OFS, 32'h0020_1011);
		P.sample(16'h0040);
		repeat (200) @(posedge pclk);
		chk(32'(input_value), 32'h0040);
	endtask
	task automatic t_error();
		wr(UIC_CTRL_OFS, 32'h0000_1011);
		wr(UIC_RANGE_OFS, 32'h0064_0000);
		P.sample(16'h0032);
		repeat (10) @(posedge pclk);
		chk(32'(scaled_value), 32'h1388);
		P.sample(16'h0100);
		repeat (10) @(posedge pclk);
		chk(32'(scaled_value), 32'h2710);
		wr(UIC_ERRTHR_OFS, 32'h0100_0010);
		wr(UIC_ERRCFG_OFS, 32'h0001_0008);
		P.sample(16'h0005);
		repeat (60) @(posedge pclk);
		chk(32'(err_low), 0);
		wr(UIC_CTRL_OFS, 32'h0100_1011);
		repeat (60) @(posedge pclk);
		chk(32'(err_low), 1);
		P.sample(16'h0014);
		repeat (10) @(posedge pclk);
		chk(32'(err_low), 1);
		P.sample(16'h0018);
		repeat (10) @(posedge pclk);
		chk(32'(err_low), 0);
		P.sample(16'h0200);
		repeat (60) @(posedge pclk);
		chk(32'(err_high), 1);
	endtask
	task automatic t_freq();
		P.half = 5;
		wr(UIC_PPR_OFS, 32'h0000_0000);
		for (int g = 0; g < 4; g++) begin
			wr(UIC_CTRL_OFS, 32'h0000_1004 | 32'(g) << 16);
			repeat (450) @(posedge pclk);
			rd_in(g == 0 ? 19 : 0, g == 0 ? 21 : 0);
		end
		wr(UIC_CTRL_OFS, 32'h0000_1004);
		wr(UIC_PPR_OFS, 32'h0000_0002);
		repeat (450) @(posedge pclk);
		rd_in(570, 630);
		wr(UIC_CTRL_OFS, 32'h0000_1005);
		repeat (450) @(posedge pclk);
		rd_in(400, 600);
	endtask
	// a lost strobe while frozen stays lost; a mid-run reset restores
	task automatic t_enable();
		wr(UIC_CTRL_OFS, 32'h0000_1011);
		P.sample(16'h0abc);
		repeat (3) @(posedge pclk);
		ce <= 1'b0;
		P.sample(16'h0def);
		repeat (40) @(posedge pclk);
		chk(32'(input_value), 32'h0000_0abc);
		ce <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(input_value), 32'h0000_0abc);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(UIC_CTRL_OFS, 32'h0000_1010);
		chk(32'(input_value), 32'h0000_0000);
	endtask
	initial begin
		presetn <= 1'b0;
		ce <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_select();
		t_logic();
		t_debounce();
		t_filter();
		t_error();
		t_freq();
		t_enable();
		conclude();
	end
	// the whole sequence needs well under a third of this
	initial begin
		repeat (30000) @(posedge pclk);
		n_mismatch++;
		$display("mismatch at %0t: run hung", $time);
		conclude();
	end
endmodule
bind uic_top uic_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .dig_in, .analog_filter_sel,
	.pull_sel, .dig_state, .scaled_value, .err_low, .err_high);
`default_nettype wire
